// ===== design/efm_pkg.sv
// Shared constants and types of the encoder feedback monitor
`default_nettype none
package efm_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [4:0] EFM_A_CTRL   = 5'h00;
  localparam logic [4:0] EFM_A_PPR    = 5'h04;
  localparam logic [4:0] EFM_A_LEVEL  = 5'h08;
  localparam logic [4:0] EFM_A_TIME   = 5'h0c;
  localparam logic [4:0] EFM_A_MAXF   = 5'h10;
  localparam logic [4:0] EFM_A_STATUS = 5'h14;
  localparam logic [4:0] EFM_A_MASK   = 5'h18;
  localparam logic [4:0] EFM_A_SPEED  = 5'h1c;
  // ---------------------------------------------------------------
  // Writable bits and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] EFM_CTRL_WM  = 32'h0000_01f7;
  localparam logic [31:0] EFM_CTRL_RST = 32'h0000_00a0;
  localparam logic [31:0] EFM_PPR_WM   = 32'h0000_7fff;
  localparam logic [31:0] EFM_PPR_RST  = 32'h0000_0258;
  localparam logic [31:0] EFM_LVL_WM   = 32'h0000_3f7f;
  localparam logic [31:0] EFM_LVL_RST  = 32'h0000_3273;
  localparam logic [31:0] EFM_TIME_WM  = 32'h007f_1f7f;
  localparam logic [31:0] EFM_TIME_RST = 32'h0005_010a;
  localparam logic [31:0] EFM_MAXF_WM  = 32'h0000_03ff;
  localparam logic [31:0] EFM_MAXF_RST = 32'h0000_003c;
  localparam logic [3:0]  EFM_ST_WM    = 4'hf;
  localparam logic [14:0] EFM_PPR_MAX  = 15'h4e20;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EFM_F_TYPE  = 0;
  localparam int EFM_F_FBT   = 4;
  localparam int EFM_F_SST   = 6;
  localparam int EFM_F_UVW   = 8;
  localparam int EFM_F_SLIP  = 8;
  localparam int EFM_F_STT   = 8;
  localparam int EFM_F_SLT   = 16;
  localparam int EFM_S_FB    = 0;
  localparam int EFM_S_SS    = 1;
  localparam int EFM_S_ALIGN = 2;
  localparam int EFM_S_SIG   = 3;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned EFM_CLK_NS      = 100;
  localparam int unsigned EFM_TICK_NS     = 100_000_000;
  localparam int unsigned EFM_TICK_CYCLES = EFM_TICK_NS / EFM_CLK_NS;
  localparam int unsigned EFM_TICKS_PER_S = 10;
  localparam logic [4:0]  EFM_ALIGN_WIN   = 5'h10;
  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EFM_IN_OFF  = 3'h0,
    EFM_QUAD_A  = 3'h1,
    EFM_QUAD_B  = 3'h2,
    EFM_PDIR_H  = 3'h3,
    EFM_PDIR_L  = 3'h4,
    EFM_SINGLE  = 3'h5
  } efm_in_t;
  typedef enum logic [1:0] {
    EFM_KEEP = 2'h0,
    EFM_RAMP = 2'h1,
    EFM_STOP = 2'h2
  } efm_treat_t;
endpackage
`default_nettype wire

// ===== design/efm_dec_if.sv
// Carrier between the monitor core and the channel decoder
`timescale 1ns/10ps
`default_nettype none
interface efm_dec_if;
  logic       a;
  logic       b;
  logic [2:0] in_type;
  logic       step;
  logic       dir;
  logic       sig_err;
  modport dec  (input a, b, in_type, output step, dir, sig_err);
  modport core (output a, b, in_type, input step, dir, sig_err);
endinterface
`default_nettype wire

// ===== design/efm_decode.sv
// Channel A/B decoder: count step and direction per input type
`timescale 1ns/10ps
`default_nettype none
module efm_decode
  import efm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  efm_dec_if.dec    port
);
  logic a_d;
  logic b_d;
  logic a_rise;
  logic quad;

  assign a_rise = port.a & ~a_d;
  assign quad   = (port.in_type == EFM_QUAD_A) || (port.in_type == EFM_QUAD_B);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_d <= 1'b0;
      b_d <= 1'b0;
    end else begin
      a_d <= port.a;
      b_d <= port.b;
    end
  end

  // One count per A rising edge in every mode except type 0, which gives no count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port.step <= 1'b0;
      port.dir  <= 1'b1;
    end else begin
      port.step <= 1'b0;
      unique case (port.in_type)
        EFM_IN_OFF: port.step <= 1'b0;                         // see R15
        EFM_QUAD_A: begin
          port.step <= a_rise;
          if (a_rise) port.dir <= ~port.b;                     // see R01
        end
        EFM_QUAD_B: begin
          port.step <= a_rise;
          if (a_rise) port.dir <= port.b;                      // see R02
        end
        EFM_PDIR_H: begin
          port.step <= a_rise;
          if (a_rise) port.dir <= port.b;                      // see R03
        end
        EFM_PDIR_L: begin
          port.step <= a_rise;
          if (a_rise) port.dir <= ~port.b;                     // see R04
        end
        EFM_SINGLE: begin
          port.step <= a_rise;
          if (a_rise) port.dir <= 1'b1;                        // see R15
        end
        default: port.step <= 1'b0;
      endcase
    end
  end

  // Both channels moving in one sample is impossible for clean quadrature
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) port.sig_err <= 1'b0;
    else port.sig_err <= quad && (port.a ^ a_d) && (port.b ^ b_d);
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_quad_fwd: assert property (port.in_type == EFM_QUAD_A && a_rise && !port.b // see R01
    |=> port.step && port.dir) else $error("quadrature A-lead not forward");
  a_quad_inv: assert property (port.in_type == EFM_QUAD_B && a_rise && !port.b // see R02
    |=> port.step && !port.dir) else $error("inverted quadrature not reverse");
  a_pdir_high: assert property (port.in_type == EFM_PDIR_H && a_rise // see R03
    |=> port.dir == $past(port.b)) else $error("pulse-direction sense wrong");
  a_pdir_low: assert property (port.in_type == EFM_PDIR_L && a_rise // see R04
    |=> port.dir != $past(port.b)) else $error("inverted pulse-direction wrong");
  a_off_quiet: assert property (port.in_type == EFM_IN_OFF // see R15
    |=> !port.step) else $error("step while input disabled");
  c_single: cover property (port.in_type == EFM_SINGLE && a_rise ##1 port.step);
endmodule
`default_nettype wire

// ===== design/efm_top.sv
// Encoder feedback monitor: decode, speed window, fault qualification
// Functional notes
// R01: Type 1: quadrature, A leading is forward, B leading is reverse.
// R02: Type 2: quadrature inverted, B leading is forward, A leading reverse.
// R03: Type 3: pulses on A, B low reverse, B high forward.
// R04: Type 4: pulses on A, B low forward, B high reverse.
// R05: Speed comparisons scale with configured pulses per revolution.
// R06: Loss, signal or setting error beyond detection time raises feedback fault.
// R07: Feedback fault treatment: 0 warn, 1 ramp stop, 2 stop output.
// R08: Feedback above stall level of max frequency is stall; 0 disables.
// R09: Speed minus motor frequency beyond slip range is slip; 0 disables.
// R10: Qualified slip or stall accumulates time in a qualification timer.
// R11: Accumulated time beyond stall detection time raises stall/slip fault.
// R12: Stall/slip fault treatment: 0 warn, 1 ramp stop, 2 coast stop.
// R13: Alignment 0: index expected at falling edge of U.
// R14: Alignment 1: index expected at rising edge of U.
// R15: Type 0 ignores inputs; type 5 counts A pulses, forward. In type 0 the code ignores only A and B; the Z/U index check still runs.
// R16: A timer clears when its condition goes away before expiry.
`timescale 1ns/10ps
`default_nettype none
module efm_top
  import efm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = EFM_TICK_CYCLES
)(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        A_IN,
  input  wire logic        B_IN,
  input  wire logic        Z_IN,
  input  wire logic        U_IN,
  input  wire logic [9:0]  MOTOR_FREQ,
  input  wire logic        RUNNING,
  output logic             DIR_FWD,
  output logic             WARN,
  output logic             RAMP_STOP,
  output logic             COAST_STOP,
  output logic             IRQ
);
  // -----------------------------------------------------------------
  // Byte lane helpers
  // -----------------------------------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be,
                                         input logic [31:0] wm);
    logic [31:0] bm;
    bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
    return (old & ~bm) | (wd & bm);
  endfunction

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] zu_d;

  assign pin_raw = {U_IN, Z_IN, B_IN, A_IN};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) zu_d <= 2'h0;
    else zu_d <= pin_sync[3:2];
  end

  // -----------------------------------------------------------------
  // Avalon slave: one wait state on every access
  // -----------------------------------------------------------------
  logic        ack;
  logic        req;
  logic        wr_en;
  logic [31:0] ctrl;
  logic [31:0] ppr_reg;
  logic [31:0] lvl_reg;
  logic [31:0] time_reg;
  logic [31:0] maxf_reg;
  logic [3:0]  status;
  logic [3:0]  mask;
  logic [3:0]  st_set;
  logic [3:0]  st_clr;
  logic [15:0] speed;

  assign req             = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack;
  assign wr_en           = AVS_WRITE & ack;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) ack <= 1'b0;
    else ack <= req & ~ack;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h0;
    end else if (AVS_READ && !ack) begin
      unique case (AVS_ADDRESS)
        EFM_A_CTRL:   AVS_READDATA <= ctrl;
        EFM_A_PPR:    AVS_READDATA <= ppr_reg;
        EFM_A_LEVEL:  AVS_READDATA <= lvl_reg;
        EFM_A_TIME:   AVS_READDATA <= time_reg;
        EFM_A_MAXF:   AVS_READDATA <= maxf_reg;
        EFM_A_STATUS: AVS_READDATA <= {28'h0, status};
        EFM_A_MASK:   AVS_READDATA <= {28'h0, mask};
        EFM_A_SPEED:  AVS_READDATA <= {15'h0, DIR_FWD, speed};
        default:      AVS_READDATA <= 32'h0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl     <= EFM_CTRL_RST;
      ppr_reg  <= EFM_PPR_RST;
      lvl_reg  <= EFM_LVL_RST;
      time_reg <= EFM_TIME_RST;
      maxf_reg <= EFM_MAXF_RST;
      mask     <= 4'h0;
    end else if (wr_en) begin
      unique case (AVS_ADDRESS)
        EFM_A_CTRL:  ctrl <= wmerge(ctrl, AVS_WRITEDATA, AVS_BYTEENABLE, EFM_CTRL_WM);
        EFM_A_PPR:   ppr_reg <= wmerge(ppr_reg, AVS_WRITEDATA, AVS_BYTEENABLE, EFM_PPR_WM);
        EFM_A_LEVEL: lvl_reg <= wmerge(lvl_reg, AVS_WRITEDATA, AVS_BYTEENABLE, EFM_LVL_WM);
        EFM_A_TIME:  time_reg <= wmerge(time_reg, AVS_WRITEDATA, AVS_BYTEENABLE, EFM_TIME_WM);
        EFM_A_MAXF:  maxf_reg <= wmerge(maxf_reg, AVS_WRITEDATA, AVS_BYTEENABLE, EFM_MAXF_WM);
        EFM_A_MASK:  if (AVS_BYTEENABLE[0]) mask <= AVS_WRITEDATA[3:0];
        default:     mask <= mask;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Field views
  // -----------------------------------------------------------------
  logic [2:0]  in_type;
  logic [1:0]  fb_treat;
  logic [1:0]  ss_treat;
  logic        uvw_rise;
  logic [14:0] ppr;
  logic [6:0]  stall_lvl;
  logic [5:0]  slip_rng;
  logic [6:0]  fb_time;
  logic [4:0]  stall_time;
  logic [6:0]  slip_time;
  logic [9:0]  maxf;

  assign in_type    = ctrl[EFM_F_TYPE +: 3];
  assign fb_treat   = ctrl[EFM_F_FBT +: 2];
  assign ss_treat   = ctrl[EFM_F_SST +: 2];
  assign uvw_rise   = ctrl[EFM_F_UVW];
  assign ppr        = ppr_reg[14:0];
  assign stall_lvl  = lvl_reg[6:0];
  assign slip_rng   = lvl_reg[EFM_F_SLIP +: 6];
  assign fb_time    = time_reg[6:0];
  assign stall_time = time_reg[EFM_F_STT +: 5];
  assign slip_time  = time_reg[EFM_F_SLT +: 7];
  assign maxf       = maxf_reg[9:0];

  // -----------------------------------------------------------------
  // Decoder
  // -----------------------------------------------------------------
  efm_dec_if dec_if ();

  assign dec_if.a       = pin_sync[0];
  assign dec_if.b       = pin_sync[1];
  assign dec_if.in_type = in_type;
  assign DIR_FWD        = dec_if.dir;

  efm_decode u_dec (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .port  (dec_if.dec)
  );

  // -----------------------------------------------------------------
  // 0.1 s time base and speed window
  // -----------------------------------------------------------------
  logic [19:0] tick_cnt;
  logic        tick;
  logic [15:0] win_cnt;
  logic        sig_seen;
  logic        sig_win;

  assign tick = (tick_cnt == 20'(TICK_CYCLES - 1));

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) tick_cnt <= 20'h0;
    else if (tick) tick_cnt <= 20'h0;
    else tick_cnt <= tick_cnt + 20'h1;
  end

  // Saturating so a runaway encoder cannot wrap to a low speed
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      win_cnt <= 16'h0;
      speed   <= 16'h0;
    end else if (tick) begin
      win_cnt <= 16'h0;
      speed   <= win_cnt;
    end else if (dec_if.step && win_cnt != 16'hffff) begin
      win_cnt <= win_cnt + 16'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sig_seen <= 1'b0;
      sig_win  <= 1'b0;
    end else if (tick) begin
      sig_seen <= dec_if.sig_err;
      sig_win  <= sig_seen;
    end else if (dec_if.sig_err) begin
      sig_seen <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Fault conditions, all in encoder counts per second
  // -----------------------------------------------------------------
  logic [39:0] fb_v;
  logic [39:0] motor_v;
  logic [39:0] max_v;
  logic [39:0] diff_v;
  logic        stall;
  logic        slip;
  logic        ppr_err;
  logic        loss;
  logic        fb_cond;

  assign fb_v    = 40'(speed) * 40'(EFM_TICKS_PER_S);
  assign motor_v = 40'(MOTOR_FREQ) * 40'(ppr);                 // see R05
  assign max_v   = 40'(maxf) * 40'(ppr);                       // see R05
  assign diff_v  = (fb_v > motor_v) ? fb_v - motor_v : motor_v - fb_v;
  assign stall   = (stall_lvl != 7'h0) &&
                   (fb_v * 40'h64 > 40'(stall_lvl) * max_v);    // see R08
  assign slip    = (slip_rng != 6'h0) && RUNNING &&
                   (diff_v * 40'h64 > 40'(slip_rng) * max_v);   // see R09
  assign ppr_err = (ppr == 15'h0) || (ppr > EFM_PPR_MAX) || (in_type > EFM_SINGLE);
  assign loss    = RUNNING && (MOTOR_FREQ != 10'h0) && (speed == 16'h0);
  assign fb_cond = ppr_err || ((in_type != EFM_IN_OFF) && (loss || sig_win));

  // -----------------------------------------------------------------
  // Qualification timers, counted in 0.1 s ticks
  // -----------------------------------------------------------------
  logic [6:0] fb_tmr;
  logic [6:0] slip_tmr;
  logic [4:0] ss_tmr;
  logic       slip_q;
  logic       ss_hold;
  logic       fb_set;
  logic       ss_set;

  assign slip_q  = slip && (slip_tmr >= slip_time);
  assign ss_hold = slip_q || stall;                             // see R10
  assign fb_set  = tick && fb_cond && (fb_tmr >= fb_time);      // see R06
  assign ss_set  = tick && ss_hold && (ss_tmr >= stall_time);   // see R11

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) fb_tmr <= 7'h0;
    else if (tick && !fb_cond) fb_tmr <= 7'h0;                 // see R16
    else if (tick && fb_tmr != 7'h7f) fb_tmr <= fb_tmr + 7'h1;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) slip_tmr <= 7'h0;
    else if (tick && !slip) slip_tmr <= 7'h0;                  // see R16
    else if (tick && slip_tmr != 7'h7f) slip_tmr <= slip_tmr + 7'h1;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) ss_tmr <= 5'h0;
    else if (tick && !ss_hold) ss_tmr <= 5'h0;                 // see R16
    else if (tick && ss_tmr != 5'h1f) ss_tmr <= ss_tmr + 5'h1; // see R10
  end

  // -----------------------------------------------------------------
  // Index against commutation edge
  // -----------------------------------------------------------------
  logic [4:0] u_age;
  logic       u_edge;
  logic       z_rise;
  logic       align_err;

  assign u_edge    = uvw_rise ? (pin_sync[3] & ~zu_d[1])       // see R14
                              : (~pin_sync[3] & zu_d[1]);      // see R13
  assign z_rise    = pin_sync[2] & ~zu_d[0];
  assign align_err = z_rise && (u_age >= EFM_ALIGN_WIN);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) u_age <= EFM_ALIGN_WIN;
    else if (u_edge) u_age <= 5'h0;
    else if (u_age != 5'h1f) u_age <= u_age + 5'h1;
  end

  // -----------------------------------------------------------------
  // Status, interrupt and stop treatment
  // -----------------------------------------------------------------
  assign st_set = {dec_if.sig_err, align_err, ss_set, fb_set};
  assign st_clr = (wr_en && AVS_ADDRESS == EFM_A_STATUS && AVS_BYTEENABLE[0]) ?
                  (AVS_WRITEDATA[3:0] & EFM_ST_WM) : 4'h0;

  // A new event beats a clear written in the same cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) status <= 4'h0;
    else status <= (status & ~st_clr) | st_set;
  end

  // Stop output and coast both cut drive output; coast dominates ramp
  logic fb_f;
  logic ss_f;
  logic next_coast;
  logic next_ramp;

  assign fb_f       = status[EFM_S_FB];
  assign ss_f       = status[EFM_S_SS];
  assign next_coast = (fb_f && fb_treat >= EFM_STOP) ||        // see R07
                      (ss_f && ss_treat >= EFM_STOP);          // see R12
  assign next_ramp  = !next_coast &&
                      ((fb_f && fb_treat == EFM_RAMP) ||       // see R07
                       (ss_f && ss_treat == EFM_RAMP));        // see R12

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WARN       <= 1'b0;
      RAMP_STOP  <= 1'b0;
      COAST_STOP <= 1'b0;
      IRQ        <= 1'b0;
    end else begin
      WARN       <= fb_f | ss_f;
      RAMP_STOP  <= next_ramp;
      COAST_STOP <= next_coast;
      IRQ        <= |(status & mask);
    end
  end

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking dc @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_bus_wait: assert property (req && !ack |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus access not answered after one wait");
  a_fb_raise: assert property (tick && fb_cond && fb_tmr >= fb_time // see R06
    |=> status[EFM_S_FB]) else $error("feedback fault not raised");
  a_fb_clear: assert property (tick && !fb_cond |=> fb_tmr == 7'h0) // see R16
    else $error("feedback timer kept after condition left");
  a_ss_accum: assert property (tick && ss_hold && ss_tmr == 5'h0 // see R10
    |=> ss_tmr == 5'h1) else $error("stall timer did not accumulate");
  a_ss_raise: assert property (tick && ss_hold && ss_tmr >= stall_time // see R11
    |=> status[EFM_S_SS]) else $error("stall or slip fault not raised");
  a_stall_count: assert property (tick && stall |=> ss_tmr != 5'h0) // see R08
    else $error("stall not accumulating time");
  a_slip_off: assert property (slip_rng == 6'h0 |-> !slip) // see R09
    else $error("slip flagged while disabled");
  a_fb_coast: assert property (fb_f && fb_treat == EFM_STOP // see R07
    |=> COAST_STOP && !RAMP_STOP) else $error("feedback stop not applied");
  a_ss_ramp: assert property (ss_f && ss_treat == EFM_RAMP && !fb_f // see R12
    |=> RAMP_STOP && WARN) else $error("stall ramp stop not applied");
  a_index_align: assert property (z_rise && u_age >= EFM_ALIGN_WIN // see R13
    |=> status[EFM_S_ALIGN]) else $error("index misalignment missed");
  a_irq_follow: assert property (status[0] && mask[0] && !st_clr[0]
    |=> IRQ) else $error("unmasked status gave no interrupt");

  c_fb_fault: cover property (fb_set);
  c_ss_fault: cover property (ss_set ##1 status[EFM_S_SS]);
  c_aligned: cover property (u_edge ##[1:8] z_rise);
  c_w1c: cover property (st_clr[EFM_S_FB] && status[EFM_S_FB]);
endmodule
`default_nettype wire

// ===== testbench/efm_enc_model.sv
// Behavioural incremental encoder with index and U-phase outputs
`timescale 1ns/10ps
`default_nettype none
module efm_enc_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic lead_a,
  input  wire logic quad,
  input  wire logic b_lvl,
  output logic      a,
  output logic      b,
  output logic      z,
  output logic      u
);
  logic [1:0] ph  = 2'h0;
  logic [1:0] cnt = 2'h0;
  // Four clocks per phase keeps each level above the three-clock minimum
  always_ff @(posedge clk) begin
    if (run) begin
      cnt <= cnt + 2'h1;
      if (cnt == 2'h3) ph <= ph + 2'h1;
    end
  end
  assign a = quad ? (lead_a ? ph[0] ^ ph[1] : ph[1]) : ph[1];
  assign b = quad ? (lead_a ? ph[1] : ph[0] ^ ph[1]) : b_lvl;
  // Index rises as U falls, matching the reset alignment choice
  assign z = (ph == 2'h0);
  assign u = ph[1];
endmodule
`default_nettype wire

// ===== testbench/efm_top_tb.sv
// Self-checking bench of the encoder feedback monitor
`timescale 1ns/10ps
`default_nettype none
module efm_top_tb
  import efm_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, wq = 1'b0;
  logic        run = 1'b0, lead_a = 1'b1, quad = 1'b1, b_lvl = 1'b0, running = 1'b0;
  logic [9:0]  mfreq = 10'h000;
  logic [4:0]  addr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat = 32'h0, q = 32'h0;
  logic [31:0] rdata;
  logic        waitreq, a, b, z, u, dir, warn, ramp, coast, irq;
  int          errors = 0, comparisons = 0;
  logic [36:0] regs [6] = '{{EFM_A_CTRL, EFM_CTRL_RST}, {EFM_A_PPR, EFM_PPR_RST},
    {EFM_A_LEVEL, EFM_LVL_RST}, {EFM_A_TIME, EFM_TIME_RST}, {EFM_A_MAXF, EFM_MAXF_RST},
    {EFM_A_MASK, 32'h0}};
  // Row: type, A leads, quadrature, B level, expected direction
  logic [6:0]  rows [9] = '{7'h1d, 7'h14, 7'h25, 7'h2c, 7'h33, 7'h30, 7'h41, 7'h42, 7'h51};
  efm_top #(.TICK_CYCLES(20)) dut_u (.CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .A_IN(a), .B_IN(b), .Z_IN(z), .U_IN(u),
    .MOTOR_FREQ(mfreq), .RUNNING(running), .DIR_FWD(dir), .WARN(warn), .RAMP_STOP(ramp),
    .COAST_STOP(coast), .IRQ(irq));
  efm_enc_model enc_u (.clk(clk), .run(run), .lead_a(lead_a), .quad(quad), .b_lvl(b_lvl),
    .a(a), .b(b), .z(z), .u(u));
  initial begin
    forever #50 clk = ~clk;
  end
  // Mid-cycle copies avoid racing the slave's own edge updates
  always @(negedge clk) begin
    wq <= waitreq;
    q <= rdata;
  end
  // ---------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= ad;
    wdat <= d;
    do @(posedge clk); while (wq);
    rdat = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      errors++;
    end
  endtask
  task automatic results;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    errors++;
    results;
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk({warn, ramp, coast, irq, dir}, 5'h01);
    foreach (regs[i]) begin
      bus(1'b0, regs[i][36:32], 32'h0);
      chk(rdat, regs[i][31:0]);
    end
    bus(1'b0, 5'h1e, 32'h0);
    chk(rdat, 32'h0);
    run <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, EFM_A_CTRL, {29'h0, rows[i][6:4]});
      {lead_a, quad, b_lvl} <= rows[i][3:1];
      repeat (48) @(posedge clk);
      chk(dir, rows[i][0]);
      bus(1'b0, EFM_A_SPEED, 32'h0);
      chk({rdat[16], rdat[15:0] != 16'h0}, {rows[i][0], 1'b1});
    end
    bus(1'b1, EFM_A_CTRL, 32'h0);
    repeat (60) @(posedge clk);
    bus(1'b0, EFM_A_SPEED, 32'h0);
    chk(rdat[15:0], 16'h0);
    bus(1'b1, EFM_A_MAXF, 32'h1);
    bus(1'b1, EFM_A_PPR, 32'h1);
    bus(1'b1, EFM_A_LEVEL, 32'h0);
    bus(1'b1, EFM_A_TIME, 32'h0005_0101);
    bus(1'b1, EFM_A_STATUS, 32'hf);
    bus(1'b1, EFM_A_CTRL, 32'h45);
    repeat (150) @(posedge clk);
    bus(1'b0, EFM_A_STATUS, 32'h0);
    chk(rdat[2:0], 3'h0);
    bus(1'b1, EFM_A_LEVEL, 32'h1);
    repeat (150) @(posedge clk);
    bus(1'b0, EFM_A_STATUS, 32'h0);
    chk(rdat[1], 1'b1);
    chk({warn, ramp, coast, irq}, 4'hc);
    bus(1'b1, EFM_A_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    run <= 1'b0;
    repeat (60) @(posedge clk);
    bus(1'b1, EFM_A_STATUS, 32'h2);
    repeat (3) @(posedge clk);
    chk({warn, irq}, 2'h0);
    bus(1'b1, EFM_A_CTRL, 32'h25);
    bus(1'b1, EFM_A_PPR, 32'h0);
    repeat (150) @(posedge clk);
    bus(1'b0, EFM_A_STATUS, 32'h0);
    chk(rdat[0], 1'b1);
    chk({warn, coast}, 2'h3);
    // Stopped encoder while the drive runs: loss and slip together
    bus(1'b1, EFM_A_PPR, 32'h1);
    bus(1'b1, EFM_A_LEVEL, 32'h100);
    bus(1'b1, EFM_A_STATUS, 32'hf);
    running <= 1'b1;
    mfreq <= 10'h001;
    repeat (250) @(posedge clk);
    bus(1'b0, EFM_A_STATUS, 32'h0);
    chk(rdat[1:0], 2'h3);
    run <= 1'b1;
    bus(1'b1, EFM_A_CTRL, 32'h101);
    repeat (40) @(posedge clk);
    bus(1'b1, EFM_A_STATUS, 32'h4);
    repeat (100) @(posedge clk);
    bus(1'b0, EFM_A_STATUS, 32'h0);
    chk(rdat[2], 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({warn, ramp, coast, irq, dir}, 5'h01);
    rst_n <= 1'b1;
    bus(1'b0, EFM_A_CTRL, 32'h0);
    chk(rdat, EFM_CTRL_RST);
    results;
  end
endmodule
`default_nettype wire
